// file: logic/jk_consts.svh
// Purpose : Constants for the falling-edge steered flip-flop pair.
// Assumes : Included by bare name from the design files.
// Notes   : Definitions only.
`ifndef JK_CONSTS_SVH
`define JK_CONSTS_SVH

// Number of flip-flops in the package and which ones honour direct set
`define JK_NUM_FF        2
`define JK_SET_MASK      2'h1

// Output levels held from reset until a direct input or clock edge acts
`define JK_Q_RST         1'b0
`define JK_QN_RST        1'b1

// Synchroniser depth for every pin and for the reset release
`define JK_SYNC_STAGES   2

// Field positions inside the packed pin vector, in units of NUM_FF bits
`define JK_FLD_STEER_A   0
`define JK_FLD_STEER_B   1
`define JK_FLD_CLK       2
`define JK_FLD_DSET      3
`define JK_FLD_DCLR      4
`define JK_NUM_FLDS      5

`endif

// file: logic/jk_pkg.sv
// Purpose : Types shared by the flip-flop pair design.
// Assumes : Nothing beyond the constants header.
// Notes   : Constants live in jk_consts.svh.
`default_nettype none

package jk_pkg;

   // What a cell does in a given cycle; decode_action sets the evaluation priority, not this order
   typedef enum logic [2:0] {
      ACT_IDLE,
      ACT_HOLD,
      ACT_LOAD_ONE,
      ACT_LOAD_ZERO,
      ACT_TOGGLE,
      ACT_DIRECT_SET,
      ACT_DIRECT_CLR,
      ACT_DIRECT_BOTH
   } action_e;

endpackage : jk_pkg

`default_nettype wire

// file: logic/pin_bus.sv
// Purpose : Carrier between the top and its pin synchroniser.
// Assumes : One clock domain, sys_clk.
// Notes   : raw is straight from pins, synced is two flops later.
`timescale 1ns/1ps
`default_nettype none

interface pin_bus #(
   parameter int W = 10
);
   logic [W-1:0] raw;
   logic [W-1:0] synced;

   modport src  (output raw,    input  synced);
   modport sync (input  raw,    output synced);
endinterface : pin_bus

`default_nettype wire

// file: logic/pin_sync.sv
// Purpose : Two-flop synchroniser for a vector of asynchronous pins.
// Assumes : Pins are independent levels; no bus coherency needed.
// Notes   : First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
`include "jk_consts.svh"

module pin_sync (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   pin_bus.sync      pins
);

   logic [$bits(pins.raw)-1:0] meta_reg;
   logic [$bits(pins.raw)-1:0] meta_next;
   logic [$bits(pins.raw)-1:0] stable_reg;
   logic [$bits(pins.raw)-1:0] stable_next;

   // Next values: shift pins through the two stages
   always_comb begin
      meta_next   = pins.raw;
      stable_next = meta_reg;
   end

   // Stage registers, cleared to low on reset
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg   <= '0;
         stable_reg <= '0;
      end else begin
         meta_reg   <= meta_next;
         stable_reg <= stable_next;
      end
   end

   assign pins.synced = stable_reg;

endmodule : pin_sync

`default_nettype wire

// file: logic/jk_pair.sv
// Purpose : Falling-edge steered flip-flops with direct set and clear, emulated on sys_clk.
// Assumes : All pins are asynchronous to sys_clk and change slower than three sys_clk periods.
// Notes   : Flip-flop 0 has direct set and clear, flip-flop 1 direct clear only (SET_MASK).
//
// Overview of operation
// - Clocked state changes only on a falling edge of the flip-flop clock pin.
// - Both steering inputs high at the falling edge: outputs keep their levels.
// - First high, second low sets; first low, second high clears, at the edge.
// - Both steering inputs low at the falling edge: outputs swap, i.e. toggle.
// - Direct set or clear forces outputs at once; both high drives both low.
// - Releasing a single direct input leaves the level it forced.
// - Releasing both direct inputs together lands on clear as one fixed choice; avoid it.
// - Reduced variant has direct clear only, same clocked steering behaviour.
// - Dual variant: two independent flip-flops, each with own pins and clear.
`timescale 1ns/1ps
`default_nettype none
`include "jk_consts.svh"

module jk_pair #(
   parameter int                 NUM_FF   = `JK_NUM_FF,
   parameter logic [NUM_FF-1:0]  SET_MASK = `JK_SET_MASK
) (
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   input  wire logic [NUM_FF-1:0] steer_a,
   input  wire logic [NUM_FF-1:0] steer_b,
   input  wire logic [NUM_FF-1:0] ff_clk,
   input  wire logic [NUM_FF-1:0] dset,
   input  wire logic [NUM_FF-1:0] dclr,
   output logic      [NUM_FF-1:0] q,
   output logic      [NUM_FF-1:0] q_n
);

   localparam int PW = NUM_FF * `JK_NUM_FLDS;

   // Reset release synchroniser
   logic rst_meta_reg;
   logic rst_meta_next;
   logic rst_sync_reg;
   logic rst_sync_next;
   logic rst_n;

   // Synchronised pin copies
   logic [NUM_FF-1:0] s_steer_a;
   logic [NUM_FF-1:0] s_steer_b;
   logic [NUM_FF-1:0] s_clk;
   logic [NUM_FF-1:0] s_dset;
   logic [NUM_FF-1:0] s_dclr;

   // Per flip-flop state
   logic [NUM_FF-1:0] q_reg;
   logic [NUM_FF-1:0] q_next;
   logic [NUM_FF-1:0] qn_reg;
   logic [NUM_FF-1:0] qn_next;
   logic [NUM_FF-1:0] clk_prev_reg;
   logic [NUM_FF-1:0] clk_prev_next;
   logic [NUM_FF-1:0] both_reg;
   logic [NUM_FF-1:0] both_next;

   jk_pkg::action_e   act [NUM_FF];

   // Pick the action of one cell from its synchronised inputs.
   // Direct inputs outrank the clock, so a clock edge during a direct
   // pulse is ignored.
   function automatic jk_pkg::action_e decode_action(
      input logic has_set,
      input logic set_d,
      input logic clr_d,
      input logic was_both,
      input logic fall,
      input logic sa,
      input logic sb
   );
      logic set_eff;
      set_eff = has_set & set_d;
      if (set_eff && clr_d) begin
         decode_action = jk_pkg::ACT_DIRECT_BOTH;
      end else if (set_eff) begin
         decode_action = jk_pkg::ACT_DIRECT_SET;
      end else if (clr_d) begin
         decode_action = jk_pkg::ACT_DIRECT_CLR;
      // Both direct inputs dropped in the same cycle: the stored state
      // would be undefined, so land on clear as one fixed choice
      end else if (was_both) begin
         decode_action = jk_pkg::ACT_DIRECT_CLR;
      end else if (!fall) begin
         decode_action = jk_pkg::ACT_IDLE;
      end else begin
         unique case ({sa, sb})
            2'h3: decode_action = jk_pkg::ACT_HOLD;
            2'h2: decode_action = jk_pkg::ACT_LOAD_ONE;
            2'h1: decode_action = jk_pkg::ACT_LOAD_ZERO;
            2'h0: decode_action = jk_pkg::ACT_TOGGLE;
         endcase
      end
   endfunction : decode_action

   // Next values of the release chain; a one walks in behind reset,
   // so the release reaches the rest of the design only after two edges
   always_comb begin
      rst_meta_next = 1'b1;
      rst_sync_next = rst_meta_reg;
   end

   // Reset is asserted at once and released through two flops
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= rst_meta_next;
         rst_sync_reg <= rst_sync_next;
      end
   end

   assign rst_n = rst_sync_reg;

   // All pins pass two flops before any logic looks at them
   pin_bus #(.W(PW)) pins ();

   assign pins.raw = {dclr, dset, ff_clk, steer_b, steer_a};

   pin_sync u_sync (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .pins    (pins)
   );

   // Unpack the synchronised vector by field
   assign s_steer_a = pins.synced[`JK_FLD_STEER_A*NUM_FF +: NUM_FF];
   assign s_steer_b = pins.synced[`JK_FLD_STEER_B*NUM_FF +: NUM_FF];
   assign s_clk     = pins.synced[`JK_FLD_CLK*NUM_FF     +: NUM_FF];
   assign s_dset    = pins.synced[`JK_FLD_DSET*NUM_FF    +: NUM_FF];
   assign s_dclr    = pins.synced[`JK_FLD_DCLR*NUM_FF    +: NUM_FF];

   // One independent cell per flip-flop, each with its own pins
   genvar gi;
   generate
      for (gi = 0; gi < NUM_FF; gi++) begin : g_ff

         // Steering is taken in the same synchronised cycle as the fall,
         // so it must settle on the pins before the clock pin drops
         // Classify this cycle; a falling clock edge is prev high, now low
         always_comb begin
            act[gi] = decode_action(SET_MASK[gi],
                                    s_dset[gi],
                                    s_dclr[gi],
                                    both_reg[gi],
                                    clk_prev_reg[gi] & ~s_clk[gi],
                                    s_steer_a[gi],
                                    s_steer_b[gi]);
         end

         // Next output levels from the chosen action
         always_comb begin
            q_next[gi]        = q_reg[gi];
            qn_next[gi]       = qn_reg[gi];
            clk_prev_next[gi] = s_clk[gi];
            both_next[gi]     = SET_MASK[gi] & s_dset[gi] & s_dclr[gi];
            unique case (act[gi])
               jk_pkg::ACT_IDLE: begin
                  q_next[gi]  = q_reg[gi];
                  qn_next[gi] = qn_reg[gi];
               end
               jk_pkg::ACT_HOLD: begin
                  q_next[gi]  = q_reg[gi];
                  qn_next[gi] = qn_reg[gi];
               end
               jk_pkg::ACT_LOAD_ONE: begin
                  q_next[gi]  = 1'b1;
                  qn_next[gi] = 1'b0;
               end
               jk_pkg::ACT_LOAD_ZERO: begin
                  q_next[gi]  = 1'b0;
                  qn_next[gi] = 1'b1;
               end
               jk_pkg::ACT_TOGGLE: begin
                  q_next[gi]  = qn_reg[gi];
                  qn_next[gi] = q_reg[gi];
               end
               jk_pkg::ACT_DIRECT_SET: begin
                  q_next[gi]  = 1'b1;
                  qn_next[gi] = 1'b0;
               end
               jk_pkg::ACT_DIRECT_CLR: begin
                  q_next[gi]  = 1'b0;
                  qn_next[gi] = 1'b1;
               end
               jk_pkg::ACT_DIRECT_BOTH: begin
                  q_next[gi]  = 1'b0;
                  qn_next[gi] = 1'b0;
               end
            endcase
         end

         // Output and edge-history registers
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               q_reg[gi]        <= `JK_Q_RST;
               qn_reg[gi]       <= `JK_QN_RST;
               clk_prev_reg[gi] <= 1'b0;
               both_reg[gi]     <= 1'b0;
            end else begin
               q_reg[gi]        <= q_next[gi];
               qn_reg[gi]       <= qn_next[gi];
               clk_prev_reg[gi] <= clk_prev_next[gi];
               both_reg[gi]     <= both_next[gi];
            end
         end

      end
   endgenerate

   // Outputs come straight from the state flops
   assign q   = q_reg;
   assign q_n = qn_reg;

endmodule : jk_pair

`default_nettype wire

// file: testbench/jk_pair_assertions.sv
// Purpose : Port-level checks on the steered flip-flop pair.
// Assumes : Outputs follow pin changes after three sys_clk edges.
// Notes   : Flip-flop 0 has direct set, flip-flop 1 clear only.
`timescale 1ns/1ps
`default_nettype none

module jk_pair_checker #(
   parameter int                NUM_FF   = 2,
   parameter logic [NUM_FF-1:0] SET_MASK = 2'h1
) (
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   input  wire logic [NUM_FF-1:0] steer_a,
   input  wire logic [NUM_FF-1:0] steer_b,
   input  wire logic [NUM_FF-1:0] ff_clk,
   input  wire logic [NUM_FF-1:0] dset,
   input  wire logic [NUM_FF-1:0] dclr,
   input  wire logic [NUM_FF-1:0] q,
   input  wire logic [NUM_FF-1:0] q_n
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   // Falling pin edge with given steering and no direct input active
   property step_p(i, code, res);
      $past(ff_clk[i], 4) && !$past(ff_clk[i], 3)
         && $past({steer_a[i], steer_b[i]} == code && !dset[i] && !dclr[i], 3) |-> res;
   endproperty

   hold_edge_a: assert property (step_p(0, 2'b11, $stable(q[0]) && $stable(q_n[0])))
      else $error("hold changed outputs");
   load_one_a: assert property (step_p(0, 2'b10, q[0] && !q_n[0]))
      else $error("load one failed");
   load_zero_a: assert property (step_p(0, 2'b01, !q[0] && q_n[0]))
      else $error("load zero failed");
   toggle_zero_a: assert property (step_p(0, 2'b00, q[0] != $past(q[0])))
      else $error("toggle failed on ff0");
   toggle_one_a: assert property (step_p(1, 2'b00, q[1] != $past(q[1])))
      else $error("toggle failed on ff1");
   direct_set_a: assert property ($past(dset[0] && !dclr[0], 3) |-> q[0] && !q_n[0])
      else $error("direct set failed");
   direct_both_a: assert property ($past(dset[0] && dclr[0], 3) |-> !q[0] && !q_n[0])
      else $error("both direct not low");
   reduced_clear_a: assert property ($past(dclr[1], 3) |-> !q[1] && q_n[1])
      else $error("ff1 clear failed");
   comp_inverse_a: assert property (q_n[1] == !q[1])
      else $error("ff1 complement wrong");
   quiet_keep_a: assert property (!($past(ff_clk[0], 4) && !$past(ff_clk[0], 3))
      && $past(!dset[0] && !dclr[0], 3) |-> $stable(q[0]))
      else $error("output moved without edge");
   full_inverse_a: assert property ($past(!(dset[0] && dclr[0]), 3) |-> q_n[0] != q[0])
      else $error("ff0 complement wrong");

   // Main scenarios reached
   cover property (step_p(0, 2'b00, 1'b1));
   cover property ($past(dset[0] && dclr[0], 3));
   cover property (step_p(1, 2'b00, 1'b1));
endmodule : jk_pair_checker

bind jk_pair jk_pair_checker #(.NUM_FF(NUM_FF), .SET_MASK(SET_MASK)) u_chk (
   .sys_clk(sys_clk), .rstn(rstn), .steer_a(steer_a), .steer_b(steer_b), .ff_clk(ff_clk),
   .dset(dset), .dclr(dclr), .q(q), .q_n(q_n));

`default_nettype wire

// file: testbench/pin_driver.sv
// Purpose : Surrounding logic that drives steering, clock and direct pins.
// Assumes : Pins change just after a rising sys_clk edge.
// Notes   : Idle steering is both high, idle clock pin is high.
`timescale 1ns/1ps
`default_nettype none

module pin_driver (
   input  wire logic       sys_clk,
   output logic      [1:0] steer_a,
   output logic      [1:0] steer_b,
   output logic      [1:0] ff_clk,
   output logic      [1:0] dset,
   output logic      [1:0] dclr
);
   // Quiet levels at time zero
   initial begin
      steer_a = 2'h3;
      steer_b = 2'h3;
      ff_clk  = 2'h3;
      dset    = 2'h0;
      dclr    = 2'h0;
   end

   // One falling clock edge with steering held well around it
   task automatic pulse(input int i, input logic a, input logic b);
      @(posedge sys_clk);
      steer_a[i] <= a; // direct pins stay low here
      steer_b[i] <= b;
      repeat (4) @(posedge sys_clk);
      ff_clk[i] <= 1'b0;
      repeat (4) @(posedge sys_clk);
      ff_clk[i] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      steer_a[i] <= 1'b1; // steering released after the edge
      steer_b[i] <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask : pulse

   // Direct levels; callers change one at a time, except one set-to-clear step on ff1
   task automatic direct(input int i, input logic s, input logic c);
      @(posedge sys_clk);
      dset[i] <= s; // clock pin stays steady
      dclr[i] <= c;
      repeat (5) @(posedge sys_clk);
   endtask : direct
endmodule : pin_driver

`default_nettype wire

// file: testbench/test_jk_pair.sv
// Purpose : Self-checking bench for the steered flip-flop pair.
// Assumes : Outputs settle three sys_clk edges after a pin change.
// Notes   : Values compared as {q, q_n} of one flip-flop.
`timescale 1ns/1ps
`default_nettype none

module test_jk_pair;
   logic       sys_clk = 1'b0;
   logic       rstn;
   logic [1:0] steer_a, steer_b, ff_clk, dset, dclr, q, q_n;
   int         bad_count = 0;
   int         check_count = 0;
   int         cyc_count = 0;

   // 10 MHz clock
   always #50 sys_clk = ~sys_clk;

   jk_pair u_dut (.sys_clk(sys_clk), .rstn(rstn), .steer_a(steer_a), .steer_b(steer_b),
      .ff_clk(ff_clk), .dset(dset), .dclr(dclr), .q(q), .q_n(q_n));
   pin_driver u_drv (.sys_clk(sys_clk), .steer_a(steer_a), .steer_b(steer_b),
      .ff_clk(ff_clk), .dset(dset), .dclr(dclr));

   // Compare one flip-flop's output pair once settled
   task automatic look(input int i, input logic [1:0] exp);
      logic [1:0] got;
      #1;
      got = {q[i], q_n[i]};
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t ff%0d got=%h exp=%h", $time, i, got, exp);
      end
   endtask : look

   task automatic summarize;
      if (bad_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   // Direct set, clear, both, staggered release on ff0
   task automatic t_direct;
      u_drv.direct(0, 1'b1, 1'b0);
      look(0, 2'b10);
      u_drv.direct(0, 1'b0, 1'b0);
      look(0, 2'b10);
      u_drv.direct(0, 1'b0, 1'b1);
      look(0, 2'b01);
      u_drv.direct(0, 1'b1, 1'b1);
      look(0, 2'b00);
      u_drv.direct(0, 1'b1, 1'b0);
      look(0, 2'b10);
      u_drv.direct(0, 1'b0, 1'b0);
      look(0, 2'b10);
   endtask : t_direct

   // Every steering code on ff0, toggling twice in a row
   task automatic t_steer;
      logic [1:0] code [6] = '{2'b01, 2'b11, 2'b00, 2'b00, 2'b10, 2'b11};
      logic [1:0] res [6] = '{2'b01, 2'b01, 2'b10, 2'b01, 2'b10, 2'b10};
      for (int k = 0; k < 6; k++) begin
         u_drv.pulse(0, code[k][1], code[k][0]);
         look(0, res[k]);
      end
   endtask : t_steer

   // Clear-only ff1: set pin ignored, preset by clear then toggle
   task automatic t_reduced;
      u_drv.direct(1, 1'b1, 1'b0);
      look(1, 2'b01);
      u_drv.direct(1, 1'b0, 1'b1);
      u_drv.direct(1, 1'b0, 1'b0);
      u_drv.pulse(1, 1'b0, 1'b0);
      look(1, 2'b10);
      u_drv.pulse(1, 1'b0, 1'b1);
      look(1, 2'b01);
      u_drv.pulse(1, 1'b1, 1'b0);
      look(1, 2'b10);
      u_drv.direct(1, 1'b0, 1'b1);
      look(1, 2'b01);
      u_drv.direct(1, 1'b0, 1'b0);
      look(0, 2'b10);
      look(1, 2'b01);
   endtask : t_reduced

   // Cut a hang short
   always @(posedge sys_clk) begin
      cyc_count <= cyc_count + 1;
      if (cyc_count == 1500) begin
         bad_count++;
         summarize();
      end
   end

   initial begin
      rstn = 1'b0;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge sys_clk);
      look(0, 2'b01);
      look(1, 2'b01);
      t_direct();
      t_steer();
      t_reduced();
      summarize();
   end
endmodule : test_jk_pair

`default_nettype wire
